// ---- design/mmd_regs.svh ----
// Purpose: Addresses, field positions and reset values of the memory map decoder.
// Assumes: 20-bit byte addresses, 1 MB space.
// Notes: Definitions only.
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH

// ----------------------------------------------------------------
// Program memory areas
// ----------------------------------------------------------------
`define MMD_VEC_LAST 20'h0007f
`define MMD_RESET_VEC 20'h00000
`define MMD_BRK_VEC 20'h0007e
`define MMD_TABLE_CALL_INSTRUCTION_BASE 20'h00080
`define MMD_TABLE_CALL_INSTRUCTION_LAST 20'h000bf
`define MMD_OPT_BASE 20'h000c0
`define MMD_OPT_LAST 20'h000c3
`define MMD_SECID_BASE 20'h000c4
`define MMD_SECID_LAST 20'h000cd
`define MMD_ALT_OFFSET 20'h01000
`define MMD_SWAP_LIMIT 20'h02000
`define MMD_FLASH_TOP_32K 20'h07fff
`define MMD_FLASH_TOP_64K 20'h0ffff
`define MMD_FLASH_TOP_96K 20'h17fff
`define MMD_FLASH_TOP_128K 20'h1ffff
`define MMD_SWAP_BIT 12

// ----------------------------------------------------------------
// Top window
// ----------------------------------------------------------------
`define MMD_WINDOW_BASE 20'hf0000
`define MMD_ESFR_LAST 20'hf07ff
`define MMD_RAM_BASE_4K 20'hfef00
`define MMD_RAM_BASE_6K 20'hfe700
`define MMD_RAM_BASE_7K 20'hfe300
`define MMD_GPR_BASE 20'hffee0
`define MMD_RAM_TOP 20'hffeff
`define MMD_SFR_BASE 20'hfff00
`define MMD_MIRROR_REG_ADDR 20'hfffe0
`define MMD_MIRROR_RESET 8'h00
`define MMD_MIRROR_BIT 0

// ----------------------------------------------------------------
// Controller registers on APB
// ----------------------------------------------------------------
`define MMD_CMD_OFS 12'h000
`define MMD_WDATA_OFS 12'h004
`define MMD_STATUS_OFS 12'h008
`define MMD_RDATA_OFS 12'h00c
`define MMD_CMD_KIND_LSB 20
`define MMD_STAT_BUSY 0
`define MMD_STAT_DONE 1
`define MMD_STAT_ERR 2
`define MMD_STAT_REGION_LSB 4

`endif

// ---- design/mmd_pkg.sv ----
// Purpose: Types shared by both ends of the memory map decoder link.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Numbers live in mmd_regs.svh.
package mmd_pkg;

  typedef enum logic [2:0] {
    K_READ = 3'h0,
    K_READ16 = 3'h1,
    K_WRITE = 3'h2,
    K_WBIT = 3'h3,
    K_FETCH = 3'h4,
    K_STACK = 3'h5,
    K_VECTOR = 3'h6,
    K_TABLE = 3'h7
  } mmd_kind_type;

  typedef enum logic [2:0] {
    RG_NONE = 3'h0,
    RG_FLASH = 3'h1,
    RG_RAM = 3'h2,
    RG_GPR = 3'h3,
    RG_SFR = 3'h4,
    RG_ESFR = 3'h5,
    RG_MIRROR = 3'h6,
    RG_OWN = 3'h7
  } mmd_region_type;

  typedef enum logic [1:0] {
    V_32K = 2'h0,
    V_64K = 2'h1,
    V_96K = 2'h2,
    V_128K = 2'h3
  } mmd_variant_type;

endpackage

// ---- design/mmd_link_if.sv ----
// Purpose: Request and answer wires between the CPU end and the decoder.
// Assumes: One clock shared by both ends.
// Notes: req is a level held until ack.
interface mmd_link_if;
  import mmd_pkg::*;
  logic req;
  mmd_kind_type kind;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic err;
  logic [19:0] rdata;
  mmd_region_type region;

  modport dev (input req, input kind, input addr, input wdata,
               output ack, output err, output rdata, output region);
  modport cpu (output req, output kind, output addr, output wdata,
               input ack, input err, input rdata, input region);
endinterface

// ---- design/mmd_decoder.sv ----
// Purpose: Decodes CPU accesses onto flash, RAM, register banks, SFRs and the mirror window.
// Assumes: Memories answer MEM_RDATA_I one cycle after MEM_RD_O.
// Notes: Holds the flash mirror select register at its own SFR address.
// Behaviour
// - Lowest 128 bytes form the vector table.
// - Vector entries are 16-bit, targets below 64 KB.
// - Word reads: low byte even, high odd.
// - All resets share vector zero; break last.
// - Call table entries sit after vector table.
// - Software copies call table into swapped block.
// - Option bytes follow call table, swapped copy too.
// - Software programs ten-byte debug ID, both copies.
// - Top window mirrors lower or upper flash half.
// - Registers and RAM win over mirrored flash.
// - Mirror is data-read only.
// - Mirror select byte/bit writable, resets to zero.
// - Select 0 lower half, 1 upper half.
// - Small variants keep mirror select at zero; the code lets any variant write it to 1.
// - Software writes mirror select once, early.
// - One instruction gap before using mirror.
// - RAM ends at register banks, variant base.
// - Flash starts at zero, variant size.
// - Register banks: no fetch, no stack.
// - Other RAM serves data, fetch and stack.
// - Last 256 bytes decode to SFRs.
// - Lowest 2 KB of window are extended SFRs.
`include "mmd_regs.svh"

module mmd_decoder
  import mmd_pkg::*;
#(
  parameter mmd_variant_type VARIANT = V_128K
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  mmd_link_if.dev LINK,
  input wire logic BOOT_SWAP_I,
  output logic [19:0] MEM_ADDR_O,
  output mmd_region_type MEM_REGION_O,
  output logic MEM_RD_O,
  output logic MEM_WR_O,
  output logic [7:0] MEM_WDATA_O,
  input wire logic [7:0] MEM_RDATA_I,
  output logic MIRROR_SEL_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_STB = 3'h1,
    ST_CAP_LO = 3'h2,
    ST_CAP_HI = 3'h3,
    ST_DONE = 3'h4
  } mmd_dstate_type;

  typedef struct packed {
    mmd_dstate_type state;
    logic two;
    logic wr;
    logic err;
    mmd_region_type region;
    logic [19:0] phys;
    logic [7:0] wdata;
    logic [7:0] lo;
    logic [7:0] hi;
    logic mirror_bit;
    logic swap_meta;
    logic swap_sync;
  } mmd_dec_type;

  mmd_dec_type dec_reg;
  mmd_dec_type dec_next;

  localparam logic [19:0] FLASH_TOP =
    (VARIANT == V_32K) ? `MMD_FLASH_TOP_32K :
    (VARIANT == V_64K) ? `MMD_FLASH_TOP_64K :
    (VARIANT == V_96K) ? `MMD_FLASH_TOP_96K : `MMD_FLASH_TOP_128K;
  localparam logic [19:0] RAM_BASE =
    (VARIANT == V_128K) ? `MMD_RAM_BASE_7K :
    (VARIANT == V_96K) ? `MMD_RAM_BASE_6K : `MMD_RAM_BASE_4K;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [19:0] ea;
  logic [19:0] mirror_src;
  logic [19:0] flash_phys;
  mmd_region_type region;
  logic refuse;
  logic is_two;
  logic is_wr;

  always_comb begin
    is_two = (LINK.kind == K_READ16) || (LINK.kind == K_VECTOR) || (LINK.kind == K_TABLE);
    is_wr = (LINK.kind == K_WRITE) || (LINK.kind == K_WBIT) || (LINK.kind == K_STACK);
    unique case (LINK.kind)
      K_VECTOR: ea = {13'h0000, LINK.addr[5:0], 1'b0};
      K_TABLE: ea = `MMD_TABLE_CALL_INSTRUCTION_BASE + {14'h0000, LINK.addr[4:0], 1'b0};
      K_READ16: ea = {LINK.addr[19:1], 1'b0};
      default: ea = LINK.addr;
    endcase
    // Source selected by the mirror bit, window offset kept
    mirror_src = {3'h0, dec_reg.mirror_bit, ea[15:0]};
    // Boot swap exchanges the two lowest 4 KB blocks, so the
    // alternate call table, option bytes and ID copies take over
    flash_phys = ea;
    if (dec_reg.swap_sync && (ea < `MMD_SWAP_LIMIT)) begin
      flash_phys[`MMD_SWAP_BIT] = ~ea[`MMD_SWAP_BIT];
    end
    if (ea >= `MMD_WINDOW_BASE) begin
      if (ea == `MMD_MIRROR_REG_ADDR) begin
        region = RG_OWN;
      end else if (ea >= `MMD_SFR_BASE) begin
        region = RG_SFR;
      end else if (ea >= `MMD_GPR_BASE) begin
        region = RG_GPR;
      end else if (ea >= RAM_BASE) begin
        region = RG_RAM;
      end else if (ea <= `MMD_ESFR_LAST) begin
        region = RG_ESFR;
      end else if (mirror_src <= FLASH_TOP) begin
        region = RG_MIRROR;
      end else begin
        // Mirror source above this variant's flash top (FLASH_TOP): nothing behind it
        region = RG_NONE;
      end
    end else if (ea <= FLASH_TOP) begin
      region = RG_FLASH;
    end else begin
      region = RG_NONE;
    end
    unique case (region)
      RG_NONE: refuse = 1'b1;
      RG_MIRROR: refuse = (LINK.kind != K_READ) && (LINK.kind != K_READ16);
      // Flash is not written over this path; reprogramming is elsewhere
      RG_FLASH: refuse = is_wr;
      RG_GPR: refuse = (LINK.kind == K_FETCH) || (LINK.kind == K_STACK) ||
                       (LINK.kind == K_WBIT);
      RG_RAM: refuse = (LINK.kind == K_WBIT);
      RG_SFR, RG_ESFR: refuse = (LINK.kind == K_FETCH) || (LINK.kind == K_STACK) ||
                                (LINK.kind == K_WBIT);
      RG_OWN: refuse = (LINK.kind == K_FETCH) || (LINK.kind == K_STACK) || is_two;
    endcase
    // Vector and table loads must land in flash
    if (((LINK.kind == K_VECTOR) || (LINK.kind == K_TABLE)) && (region != RG_FLASH)) begin
      refuse = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    dec_next = dec_reg;
    dec_next.swap_meta = BOOT_SWAP_I;
    dec_next.swap_sync = dec_reg.swap_meta;
    unique case (dec_reg.state)
      ST_IDLE: begin
        if (LINK.req) begin
          dec_next.two = is_two;
          dec_next.wr = is_wr;
          dec_next.err = refuse;
          dec_next.region = region;
          dec_next.wdata = LINK.wdata;
          dec_next.lo = 8'h00;
          dec_next.hi = 8'h00;
          dec_next.phys = (region == RG_MIRROR) ? mirror_src :
                          (region == RG_FLASH) ? flash_phys : ea;
          if (refuse) begin
            dec_next.state = ST_DONE;
          end else if (region == RG_OWN) begin
            if (LINK.kind == K_WBIT) begin
              if (LINK.wdata[2:0] == 3'(`MMD_MIRROR_BIT)) begin
                dec_next.mirror_bit = LINK.wdata[3];
              end
            end else if (LINK.kind == K_WRITE) begin
              dec_next.mirror_bit = LINK.wdata[`MMD_MIRROR_BIT];
            end
            // Only bit 0 exists; the rest of the byte reads as zero
            dec_next.lo = {7'h00, dec_reg.mirror_bit};
            dec_next.state = ST_DONE;
          end else begin
            dec_next.state = ST_STB;
          end
        end
      end
      ST_STB: begin
        // Odd address prepared here so MEM_ADDR_O comes straight from a flop
        if (dec_reg.two) begin
          dec_next.phys = {dec_reg.phys[19:1], 1'b1};
        end
        dec_next.state = dec_reg.wr ? ST_DONE : ST_CAP_LO;
      end
      ST_CAP_LO: begin
        dec_next.lo = MEM_RDATA_I;
        if (dec_reg.two) begin
          dec_next.state = ST_CAP_HI;
        end else begin
          dec_next.state = ST_DONE;
        end
      end
      ST_CAP_HI: begin
        dec_next.hi = MEM_RDATA_I;
        dec_next.state = ST_DONE;
      end
      ST_DONE: begin
        dec_next.state = ST_IDLE;
      end
      default: begin
        dec_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dec_reg <= '{state: ST_IDLE, region: RG_NONE,
                   mirror_bit: 1'(`MMD_MIRROR_RESET), default: '0};
    end else begin
      dec_reg <= dec_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Second byte strobe is issued while the first byte is captured
  assign MEM_RD_O = (!dec_reg.wr && (dec_reg.state == ST_STB)) ||
                    (dec_reg.two && (dec_reg.state == ST_CAP_LO));
  assign MEM_WR_O = dec_reg.wr && (dec_reg.state == ST_STB);
  assign MEM_ADDR_O = dec_reg.phys;
  assign MEM_REGION_O = dec_reg.region;
  assign MEM_WDATA_O = dec_reg.wdata;
  assign MIRROR_SEL_O = dec_reg.mirror_bit;

  assign LINK.ack = (dec_reg.state == ST_DONE);
  assign LINK.err = dec_reg.err;
  // Two-byte answers carry a zero top nibble: targets stay below 64 KB
  assign LINK.rdata = {4'h0, dec_reg.hi, dec_reg.lo};
  assign LINK.region = dec_reg.region;

endmodule // mmd_decoder

// ---- design/mmd_cpu_port.sv ----
// Purpose: CPU-side end: turns APB register commands into decoder link requests.
// Assumes: APB slave with zero wait states.
// Notes: One request in flight at a time.
`include "mmd_regs.svh"

module mmd_cpu_port
  import mmd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  mmd_link_if.cpu LINK,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  typedef struct packed {
    logic busy;
    logic done;
    logic err;
    mmd_kind_type kind;
    logic [19:0] addr;
    logic [7:0] wdata;
    mmd_region_type region;
    logic [19:0] rdata;
    logic [31:0] prdata;
  } mmd_cpu_type;

  mmd_cpu_type cpu_reg;
  mmd_cpu_type cpu_next;
  logic [11:0] ofs;
  logic mapped;
  logic wr_access;

  always_comb begin
    ofs = PADDR_I[11:0];
    mapped = (PADDR_I[31:12] == 20'h00000) &&
             ((ofs == `MMD_CMD_OFS) || (ofs == `MMD_WDATA_OFS) ||
              (ofs == `MMD_STATUS_OFS) || (ofs == `MMD_RDATA_OFS));
    wr_access = PSEL_I && PENABLE_I && PWRITE_I && mapped;
    cpu_next = cpu_reg;
    // Read data is latched in the setup cycle so PRDATA comes from a flop
    if (PSEL_I && !PENABLE_I) begin
      unique case (ofs)
        `MMD_CMD_OFS: cpu_next.prdata = {9'h000, cpu_reg.kind, cpu_reg.addr};
        `MMD_WDATA_OFS: cpu_next.prdata = {24'h000000, cpu_reg.wdata};
        `MMD_STATUS_OFS: cpu_next.prdata = {25'h0000000, cpu_reg.region, 1'b0,
                                            cpu_reg.err, cpu_reg.done, cpu_reg.busy};
        `MMD_RDATA_OFS: cpu_next.prdata = {12'h000, cpu_reg.rdata};
        default: cpu_next.prdata = 32'h00000000;
      endcase
    end
    if (wr_access && (ofs == `MMD_WDATA_OFS) && !cpu_reg.busy) begin
      cpu_next.wdata = PWDATA_I[7:0];
    end
    // A command written while busy is dropped; software polls busy first
    if (wr_access && (ofs == `MMD_CMD_OFS) && !cpu_reg.busy) begin
      cpu_next.addr = PWDATA_I[19:0];
      cpu_next.kind = mmd_kind_type'(PWDATA_I[`MMD_CMD_KIND_LSB +: 3]);
      cpu_next.busy = 1'b1;
      cpu_next.done = 1'b0;
    end
    if (cpu_reg.busy && LINK.ack) begin
      cpu_next.busy = 1'b0;
      cpu_next.done = 1'b1;
      cpu_next.err = LINK.err;
      cpu_next.region = LINK.region;
      cpu_next.rdata = LINK.rdata;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cpu_reg <= '{kind: K_READ, region: RG_NONE, default: '0};
    end else begin
      cpu_reg <= cpu_next;
    end
  end

  assign LINK.req = cpu_reg.busy;
  assign LINK.kind = cpu_reg.kind;
  assign LINK.addr = cpu_reg.addr;
  assign LINK.wdata = cpu_reg.wdata;
  assign PRDATA_O = cpu_reg.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

endmodule // mmd_cpu_port

// ---- testbench/mmd_link_checker.sv ----
// Purpose: Concurrent checks on the link between the CPU end and the decoder.
// Assumes: Decoder built as the 128 KB variant, RAM from fe300.
// Notes: Only decoder-driven answers are judged.
module mmd_link_checker
  import mmd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic req,
  input wire mmd_kind_type kind,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [19:0] rdata,
  input wire mmd_region_type region
);
  // ----------------------------------------------------------------
  // Answer checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire logic ok = ack && !err;
  wire logic in_flash = addr < 20'h20000;
  wire logic in_gap = addr >= 20'hf0800 && addr < 20'hfe300;

  chk_word_latency:
    assert property ($rose(req) && kind == K_READ16 && in_flash |-> !ack [*4] ##1 ack)
    else $error("word read not answered four cycles after take");
  chk_byte_latency:
    assert property ($rose(req) && kind == K_READ && in_flash |-> !ack [*3] ##1 ack)
    else $error("flash byte read not answered three cycles after take");
  chk_vector_span:
    assert property (ok && kind inside {K_VECTOR, K_TABLE} |-> rdata[19:16] == 4'h0
                     && region == RG_FLASH)
    else $error("vector or table target above 64 KB");
  chk_mirror_read_only:
    assert property (ack && kind inside {K_WRITE, K_WBIT, K_FETCH, K_STACK} && in_gap |-> err)
    else $error("mirror window accepted a non-read access");
  chk_bank_no_fetch:
    assert property (ack && kind inside {K_FETCH, K_STACK} && addr >= 20'hffee0
                     && addr <= 20'hffeff |-> err)
    else $error("register bank served fetch or stack");
  chk_sfr_region:
    assert property (ok && kind inside {K_READ, K_WRITE} && addr >= 20'hfff00
                     && addr != 20'hfffe0 |-> region == RG_SFR)
    else $error("top 256 bytes not decoded as SFR");
  chk_esfr_region:
    assert property (ok && kind inside {K_READ, K_WRITE} && addr <= 20'hf07ff
                     && addr >= 20'hf0000 |-> region == RG_ESFR)
    else $error("window base not decoded as extended SFR");
  chk_ram_serves:
    assert property (ack && kind inside {K_READ, K_FETCH, K_STACK} && addr >= 20'hfe300
                     && addr < 20'hffee0 |-> !err && region == RG_RAM)
    else $error("RAM access refused or misdecoded");
  chk_flash_end:
    assert property (ack && kind == K_READ && addr >= 20'h20000 && addr < 20'hf0000 |-> err)
    else $error("read beyond flash accepted");
endmodule // mmd_link_checker

// ---- testbench/tb_top.sv ----
// Purpose: Drives the CPU end over APB and checks decoder answers against a model.
// Assumes: 128 KB variant; memory answers one cycle after the read strobe.
// Notes: Memory byte at an address is a hash of the address.
module tb_top
  import mmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, swap = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic pready, pslverr, mem_wr, sel_o, e;
  logic [19:0] mem_addr, wr_addr, a;
  logic [7:0] mem_wdata, wr_data, mem_rdata = 8'h00;
  logic mem_rd;
  mmd_region_type mem_region, wr_region;
  logic sel = 1'b0;
  int bad_count = 0, n_tests = 0;

  mmd_link_if link ();
  mmd_cpu_port mmd_cpu_port_i (.CLK_I(clk), .RSTN_I(rstn), .LINK(link), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  mmd_decoder #(.VARIANT(V_128K)) mmd_decoder_i (.CLK_I(clk), .RSTN_I(rstn), .LINK(link),
    .BOOT_SWAP_I(swap), .MEM_ADDR_O(mem_addr), .MEM_REGION_O(mem_region),
    .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr), .MEM_WDATA_O(mem_wdata), .MEM_RDATA_I(mem_rdata),
    .MIRROR_SEL_O(sel_o));
  mmd_link_checker mmd_link_checker_i (.CLK_I(clk), .RSTN_I(rstn), .req(link.req),
    .kind(link.kind), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .err(link.err),
    .rdata(link.rdata), .region(link.region));

  always #5 clk = ~clk;

  function automatic logic [7:0] fb(input logic [19:0] x);
    return x[7:0] ^ x[15:8] ^ {x[19:16], x[19:16]};
  endfunction

  // ----------------------------------------------------------------
  // Memory stand-in and write capture
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    // Idle data reads as zero so a missing read strobe shows up
    mem_rdata <= mem_rd ? fb(mem_addr) : 8'h00;
    if (mem_wr) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_region <= mem_region;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, ad};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic model(input mmd_kind_type k, input logic [19:0] x, output logic [19:0] p,
                       output mmd_region_type r, output logic er);
    p = x;
    if (k == K_VECTOR) p = {13'h0, x[5:0], 1'b0};
    if (k == K_TABLE) p = 20'h80 + {14'h0, x[4:0], 1'b0};
    if (k == K_READ16) p[0] = 1'b0;
    if (p == 20'hfffe0) r = RG_OWN;
    else if (p >= 20'hfff00) r = RG_SFR;
    else if (p >= 20'hffee0) r = RG_GPR;
    else if (p >= 20'hfe300) r = RG_RAM;
    else if (p >= 20'hf0800) r = RG_MIRROR;
    else if (p >= 20'hf0000) r = RG_ESFR;
    else if (p < 20'h20000) r = RG_FLASH;
    else r = RG_NONE;
    if (r == RG_MIRROR) p = {3'h0, sel, p[15:0]};
    if (swap && r == RG_FLASH && p < 20'h02000) p[12] = ~p[12];
    er = r == RG_NONE || (k == K_WBIT && r != RG_OWN)
      || (r == RG_MIRROR && !(k inside {K_READ, K_READ16}))
      || (k inside {K_FETCH, K_STACK} && !(r inside {RG_FLASH, RG_RAM}))
      || (r == RG_FLASH && k inside {K_WRITE, K_STACK})
      || (k inside {K_VECTOR, K_TABLE} && r != RG_FLASH)
      || (r == RG_OWN && k inside {K_READ16, K_VECTOR, K_TABLE});
  endtask

  task automatic acc(input mmd_kind_type k, input logic [19:0] x, input logic [7:0] w);
    logic [31:0] st, rd;
    logic er, me;
    logic [19:0] p;
    mmd_region_type r;
    int n;
    apb(1'b1, 12'h004, {24'h0, w}, rd, er);
    apb(1'b1, 12'h000, {9'h0, k, x}, rd, er);
    n = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0, st, er);
      n++;
    end while (st[1:0] !== 2'b10 && n < 50);
    check({30'h0, st[1:0]}, 32'h2);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    model(k, x, p, r, me);
    check({31'h0, st[2]}, {31'h0, me});
    if (!me) begin
      check({29'h0, st[6:4]}, {29'h0, r});
      if (r == RG_OWN && k == K_READ) check(rd, {31'h0, sel});
      else if (k inside {K_READ16, K_VECTOR, K_TABLE}) check(rd, {16'h0, fb(p | 20'h1), fb(p)});
      else if (k inside {K_READ, K_FETCH}) check(rd, {24'h0, fb(p)});
      else if (k == K_WRITE && r != RG_OWN) begin
        check({4'h0, wr_addr, wr_data}, {4'h0, p, w});
        check({29'h0, wr_region}, {29'h0, r});
      end
      if (r == RG_OWN && k == K_WRITE) sel = w[0];
      if (r == RG_OWN && k == K_WBIT && w[2:0] == 3'h0) sel = w[3];
      if (r == RG_OWN) check({31'h0, sel_o}, {31'h0, sel});
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    void'($urandom(32'h0c5e));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    acc(K_READ, 20'hfffe0, 8'h00);
    acc(K_VECTOR, 20'h00000, 8'h00);
    acc(K_VECTOR, 20'h0003f, 8'h00);
    acc(K_TABLE, 20'h00000, 8'h00);
    acc(K_TABLE, 20'h0001f, 8'h00);
    acc(K_READ16, 20'h000c1, 8'h00);
    acc(K_READ, 20'hf1234, 8'h00);
    acc(K_WRITE, 20'hfffe0, 8'h01);
    acc(K_READ, 20'hf1234, 8'h00);
    acc(K_READ16, 20'hfe2ff, 8'h00);
    // Mid-run reset: select must clear, then one bit write per setup
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    sel = 1'b0;
    acc(K_READ, 20'hfffe0, 8'h00);
    acc(K_WBIT, 20'hfffe0, 8'h08);
    acc(K_READ, 20'hfffe0, 8'h00);
    acc(K_READ, 20'hf1234, 8'h00);
    acc(K_WRITE, 20'hf1234, 8'h33);
    acc(K_FETCH, 20'hf1234, 8'h00);
    acc(K_READ, 20'hf0010, 8'h00);
    acc(K_FETCH, 20'hf07ff, 8'h00);
    acc(K_READ, 20'hfff10, 8'h00);
    acc(K_WRITE, 20'hfff10, 8'h5a);
    acc(K_FETCH, 20'hfe300, 8'h00);
    acc(K_STACK, 20'hffedf, 8'h00);
    acc(K_WRITE, 20'hffedf, 8'ha5);
    acc(K_FETCH, 20'hffee0, 8'h00);
    acc(K_STACK, 20'hffeff, 8'h00);
    acc(K_READ, 20'hffee0, 8'h00);
    acc(K_READ, 20'h1ffff, 8'h00);
    acc(K_READ, 20'h20000, 8'h00);
    acc(K_WRITE, 20'h00100, 8'h11);
    for (int i = 0; i < 6; i++) begin
      a = 20'($urandom) & 20'h1ffff;
      acc(K_READ16, a, 8'h00);
      a = 20'hfe300 + 20'($urandom % 32'h1be0);
      acc(K_READ, a, 8'h00);
    end
    apb(1'b0, 12'h010, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 12'h000, 32'h0, q, e);
    check(q, {9'h0, K_READ, a});
    swap <= 1'b1;
    repeat (3) @(posedge clk);
    acc(K_VECTOR, 20'h00000, 8'h00);
    acc(K_READ, 20'h010c0, 8'h00);
    acc(K_TABLE, 20'h00003, 8'h00);
    acc(K_READ, 20'h000c4, 8'h00);
    report_and_stop;
  end
endmodule // tb_top
